// ---- rtl/fsw_cmd_front.sv ----
// Operation
// - write-enable opcode sets write latch
// - volatile enable leaves write latch alone
// - write-disable opcode clears write latch
// - latch cleared at reset and write end
// - status reads accepted even while busy
// - status byte out MSB first, repeating
// - status write touches only writable bits
// - status write needs write latch set or volatile enable in the frame before
// - status write only after 8/16 bits
// - eight bits clear complement, quad, protect one
// - valid non-volatile write runs timed busy cycle
// - latch cleared as busy rises
// - byte-two write updates complement, quad, protect one
// - read opcode, 24-bit address, data out
// - read address increments, streams until deselect
// - chip select fall starts, opcode first
// - writes abort off byte boundary
// - busy ignores all but status reads
// - quad enable bit 9, suspend bit 15
`timescale 1ns/1ps
`include "fsw_map.svh"
module fsw_cmd_front #(
    parameter int unsigned WRITE_CYCLES = `FSW_WRITE_TIME_US * `FSW_CLK_MHZ
) (
    input wire logic REF_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic CS_N_IN,
    input wire logic SCK_IN,
    input wire logic [3:0] IO_IN,
    output logic [3:0] IO_OUT,
    output logic [3:0] IO_OE_OUT,
    input wire logic QUAD_COMMAND_MODE_IN,
    output logic [23:0] MEM_ADDR_OUT,
    input wire logic [7:0] MEM_DATA_IN,
    output logic BUSY_OUT,
    output logic WRITE_LATCH_FLAG_OUT,
    output logic QUAD_LINES_ENABLE_OUT,
    output logic [15:0] STATUS_OUT
);
    logic cs_s1_r, cs_s2_r, cs_d_r;
    logic sck_s1_r, sck_s2_r, sck_d_r;
    logic [3:0] io_s1_r, io_s2_r;
    logic cs_fall, cs_rise, sck_rise, sck_fall;
    logic quad_r;
    logic [5:0] step;
    logic [5:0] cnt_r, cnt_sum;
    logic [23:0] sh_r, sh_nxt;
    logic [7:0] opc_r;
    logic [23:0] addr_r;
    fsw_pkg::fsw_state_e state_r;
    fsw_pkg::fsw_status_s st_r;
    logic vol_armed_r;
    logic [31:0] wait_cnt_r;
    logic [15:0] sr_word;
    logic [7:0] osr_r, osr_nxt, out_byte;
    logic [2:0] ocnt_r;
    logic [3:0] io_out_r, oe_r;
    logic out_state, load_evt;
    logic wr_ok, wr_exec, wr_vol;

    // two flops on every pin; select and clock get a third flop, compared with the second for edges
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            cs_d_r <= 1'b1;
            sck_s1_r <= 1'b0;
            sck_s2_r <= 1'b0;
            sck_d_r <= 1'b0;
            io_s1_r <= 4'h0;
            io_s2_r <= 4'h0;
        end else begin
            cs_s1_r <= CS_N_IN;
            cs_s2_r <= cs_s1_r;
            cs_d_r <= cs_s2_r;
            sck_s1_r <= SCK_IN;
            sck_s2_r <= sck_s1_r;
            sck_d_r <= sck_s2_r;
            io_s1_r <= IO_IN;
            io_s2_r <= io_s1_r;
        end
    end

    assign cs_fall = cs_d_r & ~cs_s2_r;
    assign cs_rise = ~cs_d_r & cs_s2_r;
    assign sck_rise = sck_s2_r & ~sck_d_r & ~cs_s2_r;
    assign sck_fall = ~sck_s2_r & sck_d_r & ~cs_s2_r;
    assign step = quad_r ? 6'h04 : 6'h01;
    assign cnt_sum = cnt_r + step;
    assign sh_nxt = quad_r ? {sh_r[19:0], io_s2_r} : {sh_r[22:0], io_s2_r[0]};

    // opcode, address and data framing
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state_r <= fsw_pkg::ST_IDLE;
            cnt_r <= 6'h00;
            sh_r <= 24'h000000;
            opc_r <= 8'h00;
            quad_r <= 1'b0;
        end else if (cs_rise) begin
            state_r <= fsw_pkg::ST_IDLE;
        end else if (cs_fall) begin
            state_r <= fsw_pkg::ST_OPCODE;
            cnt_r <= 6'h00;
            sh_r <= 24'h000000;
            quad_r <= QUAD_COMMAND_MODE_IN;
        end else if (sck_rise) begin
            sh_r <= sh_nxt;
            if (cnt_r < `FSW_CNT_CLAMP) begin
                cnt_r <= cnt_sum;
            end
            unique case (state_r)
                fsw_pkg::ST_OPCODE: begin
                    if (cnt_sum == `FSW_OPCODE_BITS) begin
                        opc_r <= sh_nxt[7:0];
                        cnt_r <= 6'h00;
                        if (st_r.busy && sh_nxt[7:0] != `FSW_OP_RDSR1 && sh_nxt[7:0] != `FSW_OP_RDSR2) begin
                            state_r <= fsw_pkg::ST_DISCARD;
                        end else begin
                            unique case (sh_nxt[7:0])
                                `FSW_OP_RDSR1, `FSW_OP_RDSR2: state_r <= fsw_pkg::ST_STATOUT;
                                `FSW_OP_READ: state_r <= fsw_pkg::ST_ADDR;
                                `FSW_OP_WRSR, `FSW_OP_WRSR2: state_r <= fsw_pkg::ST_WDATA;
                                `FSW_OP_WREN, `FSW_OP_WRDI, `FSW_OP_WREN_VOL: state_r <= fsw_pkg::ST_SIMPLE;
                                default: state_r <= fsw_pkg::ST_DISCARD;
                            endcase
                        end
                    end
                end
                fsw_pkg::ST_ADDR: begin
                    if (cnt_sum == `FSW_ADDR_BITS) begin
                        state_r <= fsw_pkg::ST_DATAOUT;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    assign out_state = (state_r == fsw_pkg::ST_STATOUT) || (state_r == fsw_pkg::ST_DATAOUT);
    assign load_evt = sck_fall && out_state && (ocnt_r == 3'h0);

    // address capture, then one step per byte handed out
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            addr_r <= 24'h000000;
        end else if (sck_rise && state_r == fsw_pkg::ST_ADDR && cnt_sum == `FSW_ADDR_BITS) begin
            addr_r <= sh_nxt;
        end else if (load_evt && state_r == fsw_pkg::ST_DATAOUT) begin
            addr_r <= addr_r + 24'h000001;
        end
    end

    // status write qualification, decided at deselect
    always_comb begin
        wr_ok = 1'b0;
        if (state_r == fsw_pkg::ST_WDATA) begin
            if (opc_r == `FSW_OP_WRSR) begin
                wr_ok = (cnt_r == `FSW_BYTE_BITS) || (cnt_r == `FSW_WORD_BITS);
            end else begin
                wr_ok = (cnt_r == `FSW_BYTE_BITS);
            end
        end
    end
    assign wr_vol = vol_armed_r;
    assign wr_exec = cs_rise && wr_ok && !st_r.busy && (st_r.write_latch_flag || wr_vol);

    // status bits and timed write cycle
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            st_r <= '0;
            vol_armed_r <= 1'b0;
            wait_cnt_r <= 32'h00000000;
        end else begin
            if (st_r.busy) begin
                if (wait_cnt_r >= WRITE_CYCLES - 32'h00000001) begin
                    st_r.busy <= 1'b0;
                    st_r.write_latch_flag <= 1'b0;
                end else begin
                    wait_cnt_r <= wait_cnt_r + 32'h00000001;
                end
            end
            if (cs_rise) begin
                // volatile arming survives only into the very next frame
                vol_armed_r <= 1'b0;
                if (state_r == fsw_pkg::ST_SIMPLE && cnt_r == 6'h00 && !st_r.busy) begin
                    unique case (opc_r)
                        `FSW_OP_WREN: st_r.write_latch_flag <= 1'b1;
                        `FSW_OP_WRDI: st_r.write_latch_flag <= 1'b0;
                        `FSW_OP_WREN_VOL: vol_armed_r <= 1'b1;
                        default: begin
                        end
                    endcase
                end
            end
            if (wr_exec) begin
                if (opc_r == `FSW_OP_WRSR2) begin
                    st_r.protect_complement <= sh_r[6];
                    st_r.quad_lines_enable <= sh_r[1];
                    st_r.status_protect_bit_one <= sh_r[0];
                end else if (cnt_r == `FSW_BYTE_BITS) begin
                    st_r.status_protect_bit_zero <= sh_r[7];
                    st_r.protect_complement <= 1'b0;
                    st_r.quad_lines_enable <= 1'b0;
                    st_r.status_protect_bit_one <= 1'b0;
                end else begin
                    st_r.status_protect_bit_zero <= sh_r[15];
                    st_r.protect_complement <= sh_r[6];
                    st_r.quad_lines_enable <= sh_r[1];
                    st_r.status_protect_bit_one <= sh_r[0];
                end
                // volatile loads skip the timed cycle and leave the latch alone
                if (!wr_vol) begin
                    st_r.busy <= 1'b1;
                    st_r.write_latch_flag <= 1'b0;
                    wait_cnt_r <= 32'h00000000;
                end
            end
        end
    end

    assign sr_word = fsw_pkg::fsw_status_word(st_r);
    assign out_byte = (state_r == fsw_pkg::ST_DATAOUT) ? MEM_DATA_IN :
        ((opc_r == `FSW_OP_RDSR1) ? sr_word[7:0] : sr_word[15:8]);

    always_comb begin
        if (ocnt_r == 3'h0) begin
            osr_nxt = out_byte;
        end else if (quad_r) begin
            osr_nxt = {osr_r[3:0], 4'h0};
        end else begin
            osr_nxt = {osr_r[6:0], 1'b0};
        end
    end

    // output shifter, advances on link clock falling edges
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            osr_r <= 8'h00;
            ocnt_r <= 3'h0;
            io_out_r <= 4'h0;
            oe_r <= 4'h0;
        end else if (cs_rise || cs_fall) begin
            ocnt_r <= 3'h0;
            oe_r <= 4'h0;
        end else if (sck_fall && out_state) begin
            osr_r <= osr_nxt;
            ocnt_r <= ocnt_r + step[2:0];
            io_out_r <= quad_r ? osr_nxt[7:4] : {2'b00, osr_nxt[7], 1'b0};
            oe_r <= quad_r ? `FSW_OE_QUAD : `FSW_OE_SERIAL;
        end
    end

    assign IO_OUT = io_out_r;
    assign IO_OE_OUT = oe_r;
    assign MEM_ADDR_OUT = addr_r;
    assign BUSY_OUT = st_r.busy;
    assign WRITE_LATCH_FLAG_OUT = st_r.write_latch_flag;
    assign QUAD_LINES_ENABLE_OUT = st_r.quad_lines_enable;
    assign STATUS_OUT = sr_word;
endmodule

// ---- rtl/fsw_map.svh ----
`ifndef FSW_MAP_SVH
`define FSW_MAP_SVH
`define FSW_OP_WREN 8'h06
`define FSW_OP_WREN_VOL 8'h50
`define FSW_OP_WRDI 8'h04
`define FSW_OP_RDSR1 8'h05
`define FSW_OP_RDSR2 8'h35
`define FSW_OP_WRSR 8'h01
`define FSW_OP_WRSR2 8'h31
`define FSW_OP_READ 8'h03
`define FSW_OPCODE_BITS 6'h08
`define FSW_ADDR_BITS 6'h18
`define FSW_BYTE_BITS 6'h08
`define FSW_WORD_BITS 6'h10
`define FSW_CNT_CLAMP 6'h28
`define FSW_BIT_BUSY 0
`define FSW_BIT_WRITE_LATCH 1
`define FSW_BIT_PROTECT_ZERO 7
`define FSW_BIT_PROTECT_ONE 8
`define FSW_BIT_QUAD_ENABLE 9
`define FSW_BIT_COMPLEMENT 14
`define FSW_BIT_SUSPEND 15
`define FSW_OE_SERIAL 4'h2
`define FSW_OE_QUAD 4'hf
`define FSW_CLK_MHZ 25
`define FSW_WRITE_TIME_US 1000
`endif

// ---- rtl/fsw_pkg.sv ----
`include "fsw_map.svh"
package fsw_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_OPCODE,
        ST_SIMPLE,
        ST_ADDR,
        ST_WDATA,
        ST_STATOUT,
        ST_DATAOUT,
        ST_DISCARD
    } fsw_state_e;

    typedef struct packed {
        logic suspended_flag;
        logic protect_complement;
        logic quad_lines_enable;
        logic status_protect_bit_one;
        logic status_protect_bit_zero;
        logic write_latch_flag;
        logic busy;
    } fsw_status_s;

    function automatic logic [15:0] fsw_status_word(input fsw_status_s st);
        logic [15:0] w;
        w = 16'h0000;
        w[`FSW_BIT_BUSY] = st.busy;
        w[`FSW_BIT_WRITE_LATCH] = st.write_latch_flag;
        w[`FSW_BIT_PROTECT_ZERO] = st.status_protect_bit_zero;
        w[`FSW_BIT_PROTECT_ONE] = st.status_protect_bit_one;
        w[`FSW_BIT_QUAD_ENABLE] = st.quad_lines_enable;
        w[`FSW_BIT_COMPLEMENT] = st.protect_complement;
        w[`FSW_BIT_SUSPEND] = st.suspended_flag;
        return w;
    endfunction
endpackage

// ---- verification/fsw_cmd_front_sva.sv ----
`timescale 1ns/1ps
module fsw_cmd_front_sva #(
    parameter int unsigned WRITE_CYCLES = 20
) (
    input wire logic REF_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic CS_N_IN,
    input wire logic [3:0] IO_OE_OUT,
    input wire logic BUSY_OUT,
    input wire logic WRITE_LATCH_FLAG_OUT,
    input wire logic QUAD_LINES_ENABLE_OUT,
    input wire logic [15:0] STATUS_OUT
);
    int unsigned busy_cnt_r;
    // counter instead of a long repetition, which the tools would unroll
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            busy_cnt_r <= 0;
        end else begin
            busy_cnt_r <= BUSY_OUT ? busy_cnt_r + 1 : 0;
        end
    end
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    reset_clear_a: assert property ($rose(RST_N_IN) |-> STATUS_OUT == 16'h0000)
        else $error("status not clear after reset");
    mirror_bits_a: assert property (BUSY_OUT == STATUS_OUT[0] && WRITE_LATCH_FLAG_OUT == STATUS_OUT[1]
        && QUAD_LINES_ENABLE_OUT == STATUS_OUT[9]) else $error("flag ports disagree with status");
    fixed_zero_a: assert property ((STATUS_OUT & 16'hbc7c) == 16'h0000)
        else $error("read-only status bit set");
    latch_drop_a: assert property ($rose(BUSY_OUT) |-> !WRITE_LATCH_FLAG_OUT && $past(WRITE_LATCH_FLAG_OUT))
        else $error("latch not dropped as busy rose");
    busy_length_a: assert property ($fell(BUSY_OUT) |-> busy_cnt_r == WRITE_CYCLES)
        else $error("write cycle length wrong");
    busy_start_a: assert property ($rose(BUSY_OUT) |-> CS_N_IN) else $error("busy rose while selected");
    latch_set_a: assert property ($rose(WRITE_LATCH_FLAG_OUT) |-> CS_N_IN && !BUSY_OUT)
        else $error("latch set while busy or selected");
    frame_stable_a: assert property (!CS_N_IN [*6] |-> $stable(STATUS_OUT[15:1]))
        else $error("status changed inside a frame");
    idle_release_a: assert property (CS_N_IN [*6] |-> IO_OE_OUT == 4'h0)
        else $error("lines driven while deselected");
    oe_shape_a: assert property (IO_OE_OUT == 4'h0 || IO_OE_OUT == 4'h2 || IO_OE_OUT == 4'hf)
        else $error("illegal enable pattern");
endmodule
bind fsw_cmd_front fsw_cmd_front_sva #(.WRITE_CYCLES(WRITE_CYCLES)) i_fsw_cmd_front_sva (.REF_CLK_IN, .RST_N_IN,
    .CS_N_IN, .IO_OE_OUT, .BUSY_OUT, .WRITE_LATCH_FLAG_OUT, .QUAD_LINES_ENABLE_OUT, .STATUS_OUT);

// ---- verification/fsw_cmd_front_tb.sv ----
`timescale 1ns/1ps
module fsw_cmd_front_tb;
    localparam int WC = 400;
    logic ref_clk, rst_n, cs_n, sck, busy, lat, quad_en, qcm;
    logic [3:0] io, io_o, oe;
    logic [23:0] addr;
    logic [15:0] st, e;
    logic [31:0] d;
    int miscompares = 0;
    int num_checks = 0;
    function automatic logic [7:0] f(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction
    fsw_cmd_front #(.WRITE_CYCLES(WC)) i_fsw_cmd_front (.REF_CLK_IN(ref_clk), .RST_N_IN(rst_n), .CS_N_IN(cs_n),
        .SCK_IN(sck), .IO_IN(io), .IO_OUT(io_o), .IO_OE_OUT(oe), .QUAD_COMMAND_MODE_IN(qcm),
        .MEM_ADDR_OUT(addr), .MEM_DATA_IN(f(addr)), .BUSY_OUT(busy), .WRITE_LATCH_FLAG_OUT(lat),
        .QUAD_LINES_ENABLE_OUT(quad_en), .STATUS_OUT(st));
    // undriven lines read back inverted, so a missing enable cannot pass
    fsw_host_model i_fsw_host_model (.clk_in(ref_clk), .io_in(~(io_o ^ oe)), .qm_in(qcm), .cs_n_out(cs_n),
        .sck_out(sck), .io_out(io));
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        num_checks++;
        if (g !== x) begin
            miscompares++;
            $display("FAIL t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    task automatic sx(input logic [7:0] c, input int nb, input logic [31:0] v, input int nr);
        i_fsw_host_model.xfer(c, nb, v, nr);
        chk(st, e);
    endtask
    task automatic wbusy;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < WC + 40) begin
            @(negedge ref_clk);
            n++;
        end
        e[0] = 1'b0;
        chk(st, e);
    endtask
    task automatic finish_test;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    initial begin
        #2000000;
        miscompares++;
        finish_test();
    end
    initial begin
        rst_n = 1'b0;
        qcm = 1'b0;
        d = $urandom(64839);
        repeat (16) @(negedge ref_clk);
        rst_n = 1'b1;
        e = 16'h0000;
        repeat (4) @(negedge ref_clk);
        chk(st, e);
        e[1] = 1'b1;
        sx(8'h06, 0, 0, 0);
        sx(8'h05, 0, 0, 16);
        chk(i_fsw_host_model.rd[15:0], {2{e[7:0]}});
        e[1] = 1'b0;
        sx(8'h04, 0, 0, 0);
        d = $urandom;
        sx(8'h01, 16, d, 0);
        $display("test latch done");
        sx(8'h50, 0, 0, 0);
        d = $urandom;
        e = {1'b0, d[6], 4'h0, d[1], d[0], d[15], 7'h00};
        sx(8'h01, 16, d, 0);
        sx(8'h35, 0, 0, 8);
        chk(i_fsw_host_model.rd[7:0], e[15:8]);
        $display("test volatile done");
        e[1] = 1'b1;
        sx(8'h06, 0, 0, 0);
        sx(8'h01, 12, $urandom, 0);
        d = $urandom;
        e = {8'h00, d[7], 7'h01};
        sx(8'h01, 8, d, 0);
        sx(8'h06, 0, 0, 0);
        sx(8'h05, 0, 0, 8);
        chk(i_fsw_host_model.rd[7:0], e[7:0]);
        wbusy();
        $display("test byte write done");
        e[1] = 1'b1;
        sx(8'h06, 0, 0, 0);
        d = $urandom;
        {e[14], e[9], e[8], e[1], e[0]} = {d[6], d[1], d[0], 2'b01};
        sx(8'h31, 8, d, 0);
        wbusy();
        chk(quad_en, e[9]);
        $display("test second byte done");
        qcm = 1'b1;
        sx(8'h50, 0, 0, 0);
        d = $urandom | 32'h000000bc;
        e = {1'b0, d[6], 4'h0, d[1], d[0], d[15], 7'h00};
        sx(8'h01, 16, d, 0);
        sx(8'h35, 0, 0, 8);
        chk(i_fsw_host_model.rd[7:0] & 8'h43, e[15:8] & 8'h43);
        e[1] = 1'b1;
        sx(8'h06, 0, 0, 0);
        sx(8'h05, 0, 0, 16);
        chk(i_fsw_host_model.rd[15:0], {2{e[7:0]}});
        qcm = 1'b0;
        $display("test quad done");
        rst_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        rst_n = 1'b1;
        e = 16'h0000;
        repeat (4) @(negedge ref_clk);
        chk(st, e);
        $display("test reset done");
        d = $urandom;
        sx(8'h03, 24, d, 24);
        chk(i_fsw_host_model.rd[23:0], {f(d[23:0]), f(d[23:0] + 24'h1), f(d[23:0] + 24'h2)});
        $display("test read done");
        finish_test();
    end
endmodule

// ---- verification/fsw_host_model.sv ----
`timescale 1ns/1ps
module fsw_host_model (
    input wire logic clk_in,
    input wire logic [3:0] io_in,
    input wire logic qm_in,
    output logic cs_n_out,
    output logic sck_out,
    output logic [3:0] io_out
);
    logic [31:0] rd;
    initial begin
        cs_n_out = 1'b1;
        sck_out = 1'b0;
        io_out = 4'h0;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    // mode 0 frame; clock still outside frames, idle data toggles so no stale value
    task automatic xfer(input logic [7:0] op, input int nb, input logic [31:0] d, input int nr);
        logic [63:0] sh;
        int w;
        sh = {op, d << (32 - nb), 24'h000000};
        w = qm_in ? 4 : 1;
        wt(1);
        cs_n_out = 1'b0;
        wt(4);
        for (int i = 0; i < (8 + nb + nr) / w; i++) begin
            sck_out = 1'b0;
            if (w * i >= 8 + nb) begin
                io_out = ~io_out;
            end else if (w == 4) begin
                io_out = sh[63 - 4 * i -: 4];
            end else begin
                io_out[0] = sh[63 - i];
            end
            wt(4);
            sck_out = 1'b1;
            wt(4);
            if (w * i >= 8 + nb) rd = (w == 4) ? {rd[27:0], io_in} : {rd[30:0], io_in[1]};
        end
        sck_out = 1'b0;
        wt(4);
        cs_n_out = 1'b1;
        io_out[0] = ~io_out[0];
        wt(12);
    endtask
endmodule
